//--- rtl/mfi_map.vh
// constants for the multifunction input block: register offsets,
// field positions, reset values, function codes and timing counts.
// assumes a 125 MHz ref_clk_i and a 32-bit AHB-Lite register port.
//
// Summary of operation
// - sample/hold input on: latch analog reference 100 ms later, run at it.
// - sample/hold input dropping before 100 ms latches nothing.
// - held reference is discarded at power-down, never survives a cycle.
// - sample/hold with ramp hold, up/down or trim flags config error.
// - source-select code 2 follows input level only while drive stopped.
// - source input off: terminals; on: option board for reference and run.
// - code 12 jogs forward, 13 jogs reverse, no run command needed.
// - jog frequency 0 to 120.00, default 6.00 Hz, writable while running.
// - jog frequency unit follows display unit, default 0.01 Hz steps.
// - jog frequency overrides every other frequency reference.
// - both jog inputs on 500 ms or more: stop by stop method.
// - codes 20 to 2F are external faults; 20 to 2B drive the fault contact.
// - fault indication carries the signalling terminal number.
// - even codes fault while on, odd codes fault while off.
// - bit 1 clear detects always, bit 1 set only while running.
// - action by code: decel, coast, emergency stop, or warn and run.
// - each of ten terminals has its own function select.
`ifndef MFI_MAP_VH
`define MFI_MAP_VH

`define MFI_CLK_NS       8
`define MFI_TICK_NS      1000000
`define MFI_TICK_CYC     (`MFI_TICK_NS / `MFI_CLK_NS)
`define MFI_HOLD_MS      100
`define MFI_DUAL_MS      500
`define MFI_HOLD_TICKS   (`MFI_HOLD_MS * 1000000 / `MFI_TICK_NS)
`define MFI_DUAL_TICKS   (`MFI_DUAL_MS * 1000000 / `MFI_TICK_NS)

`define MFI_A_FUNC0      6'h00
`define MFI_A_JOG        6'h28
`define MFI_A_CFG        6'h2C
`define MFI_A_STAT       6'h30
`define MFI_A_HELD       6'h34
`define MFI_A_IRQ        6'h38
`define MFI_A_MASK       6'h3C

`define MFI_FUNC_RST     8'hFF
`define MFI_JOG_RST      16'h0258
`define MFI_JOG_MAX      16'h2EE0
`define MFI_CFG_RST      8'h05

`define MFI_F_SRC        8'h02
`define MFI_F_RAMP       8'h0A
`define MFI_F_UP         8'h10
`define MFI_F_DOWN       8'h11
`define MFI_F_JOG_FWD    8'h12
`define MFI_F_JOG_REV    8'h13
`define MFI_F_TRIM_UP    8'h1C
`define MFI_F_TRIM_DN    8'h1D
`define MFI_F_HOLD       8'h1E
`define MFI_F_EF_HI      4'h2

`define MFI_ACT_WARN     2'h3
`define MFI_TERM_BASE    4'h3

`define MFI_IRQ_HOLD     0
`define MFI_IRQ_DUAL     1
`define MFI_IRQ_FAULT    2
`define MFI_IRQ_WARN     3
`define MFI_IRQ_CFG      4
`define MFI_IRQ_W        5

`endif

//--- rtl/mfi_delay.v
// tick-based qualifying delay: done once cond has held for LIMIT + 1 ticks.
// assumes tick_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
module mfi_delay #(
    parameter W     = 10,
    parameter LIMIT = 100
) (
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire tick_i,
    input  wire cond_i,
    output wire done_o
);
    localparam [31:0]  END_FULL = LIMIT + 1;
    localparam [W-1:0] END_CNT  = END_FULL[W-1:0];

    reg [W-1:0] cnt_q;
    reg [W-1:0] cnt_d;

    // one extra tick so a partial first tick never shortens the wait
    always @* begin
        cnt_d = cnt_q;
        if (!cond_i) begin
            cnt_d = {W{1'b0}};
        end else if (tick_i && cnt_q != END_CNT) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = (cnt_q == END_CNT);
endmodule

//--- rtl/mfi_top.v
// multifunction digital input logic with an AHB-Lite register port.
// assumes terminal pins are asynchronous; analog reference and the
// running flag come from logic on ref_clk_i; rst_i marks power-up.
`timescale 1ns/1ns
`include "mfi_map.vh"
module mfi_top #(
    parameter NTERM    = 10,
    parameter TICK_CYC = `MFI_TICK_CYC
) (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire        hreadyout_o,
    output wire [31:0] hrdata_o,
    output wire        hresp_o,
    input  wire [9:0]  term_i,
    input  wire [15:0] analog_ref_i,
    input  wire        running_i,
    output wire [15:0] freq_ref_o,
    output wire        src_option_o,
    output wire        jog_run_o,
    output wire        jog_rev_o,
    output wire        jog_stop_o,
    output wire [1:0]  stop_method_o,
    output wire [1:0]  display_unit_o,
    output wire        fault_contact_o,
    output wire        fault_warn_o,
    output wire [1:0]  fault_action_o,
    output wire [3:0]  fault_term_o,
    output wire        cfg_err_o,
    output wire        irq_o
);
    localparam [31:0] TICK_END = TICK_CYC - 1;

    function any_code;
        input [79:0] f;
        input [7:0]  c;
        integer k;
        begin
            any_code = 1'b0;
            for (k = 0; k < 10; k = k + 1) begin
                if (f[k*8 +: 8] == c) begin
                    any_code = 1'b1;
                end
            end
        end
    endfunction

    function term_on;
        input [79:0] f;
        input [9:0]  t;
        input [7:0]  c;
        integer k;
        begin
            term_on = 1'b0;
            for (k = 0; k < 10; k = k + 1) begin
                if (f[k*8 +: 8] == c && t[k]) begin
                    term_on = 1'b1;
                end
            end
        end
    endfunction

    // register file
    reg [79:0] func_q;
    reg [15:0] jog_q;
    reg [7:0]  cfg_q;
    reg [15:0] held_q;
    reg [`MFI_IRQ_W-1:0] irq_q;
    reg [`MFI_IRQ_W-1:0] mask_q;

    // bus state
    reg        wr_q;
    reg [5:0]  wa_q;
    reg [31:0] hrdata_q;
    reg        hreadyout_q;
    reg        hresp_q;

    // pin synchronisers
    reg [9:0]  t_m_q;
    reg [9:0]  t_q;

    // behaviour state
    reg [31:0] tick_cnt_q;
    reg        tick_q;
    reg        hold_valid_q;
    reg        hold_done_q;
    reg        src_q;
    reg        dual_stop_q;
    reg        fault_q;
    reg        fcont_q;
    reg        fwarn_q;
    reg [1:0]  fact_q;
    reg [3:0]  fterm_q;
    reg        cfg_err_q;
    reg [15:0] freq_q;
    reg        jog_run_q;
    reg        jog_rev_q;
    reg        irq_out_q;

    wire       a_ok = hsel_i & htrans_i[1] & hready_i;
    wire [5:0] a_idx = {haddr_i[5:2], 2'b00};
    wire       wr_now = wr_q;

    wire sh_on   = term_on(func_q, t_q, `MFI_F_HOLD);
    wire src_in  = term_on(func_q, t_q, `MFI_F_SRC);
    wire jog_fwd = term_on(func_q, t_q, `MFI_F_JOG_FWD);
    wire jog_rev = term_on(func_q, t_q, `MFI_F_JOG_REV);
    wire sh_cfg  = any_code(func_q, `MFI_F_HOLD);
    wire clash   = any_code(func_q, `MFI_F_RAMP)
                 | any_code(func_q, `MFI_F_UP)
                 | any_code(func_q, `MFI_F_DOWN)
                 | any_code(func_q, `MFI_F_TRIM_UP)
                 | any_code(func_q, `MFI_F_TRIM_DN);
    wire cfg_err = sh_cfg & clash;

    wire hold_done;
    wire dual_done;

    mfi_delay #(
        .W     (10),
        .LIMIT (`MFI_HOLD_TICKS)
    ) u_hold (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_q),
        .cond_i    (sh_on),
        .done_o    (hold_done)
    );

    mfi_delay #(
        .W     (10),
        .LIMIT (`MFI_DUAL_TICKS)
    ) u_dual (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_q),
        .cond_i    (jog_fwd & jog_rev),
        .done_o    (dual_done)
    );

    // external fault detection, one slice per terminal
    wire [NTERM-1:0] ef_det;
    genvar gi;
    generate
        for (gi = 0; gi < NTERM; gi = gi + 1) begin : g_ef
            wire [7:0] fc = func_q[gi*8 +: 8];
            wire is_ef = (fc[7:4] == `MFI_F_EF_HI);
            wire lvl = fc[0] ? ~t_q[gi] : t_q[gi];
            wire en = fc[1] ? running_i : 1'b1;
            assign ef_det[gi] = is_ef & lvl & en;
        end
    endgenerate

    // lowest-numbered terminal wins when several fault at once
    reg [3:0] ef_idx;
    reg [1:0] ef_act;
    integer   j;
    always @* begin
        ef_idx = 4'h0;
        ef_act = 2'h0;
        for (j = NTERM - 1; j >= 0; j = j - 1) begin
            if (ef_det[j]) begin
                ef_idx = j[3:0];
                ef_act = func_q[j*8+2 +: 2];
            end
        end
    end
    wire ef_any = |ef_det;

    // bus write decode
    wire        wr_func = wr_now && wa_q < `MFI_A_JOG;
    wire [3:0]  wf_idx  = wa_q[5:2];
    wire        wr_jog  = wr_now && wa_q == `MFI_A_JOG;
    wire        wr_cfg  = wr_now && wa_q == `MFI_A_CFG;
    wire        wr_irq  = wr_now && wa_q == `MFI_A_IRQ;
    wire        wr_mask = wr_now && wa_q == `MFI_A_MASK;
    wire [`MFI_IRQ_W-1:0] irq_clr =
        wr_irq ? hwdata_i[`MFI_IRQ_W-1:0] : {`MFI_IRQ_W{1'b0}};
    wire f_clr = irq_clr[`MFI_IRQ_FAULT] | irq_clr[`MFI_IRQ_WARN];

    // events
    wire ev_hold  = hold_done & ~hold_done_q;
    wire ev_dual  = dual_done & ~dual_stop_q;
    wire ev_fault = ef_any & ~fault_q & (ef_act != `MFI_ACT_WARN);
    wire ev_warn  = ef_any & ~fault_q & (ef_act == `MFI_ACT_WARN);
    wire ev_cfg   = cfg_err & ~cfg_err_q;
    wire [`MFI_IRQ_W-1:0] ev = {ev_cfg, ev_warn, ev_fault, ev_dual,
                                ev_hold};

    wire [31:0] stat_w = {18'h0, fact_q, fterm_q, 1'b0, fault_q,
                          cfg_err_q, dual_stop_q, jog_rev_q, jog_run_q,
                          src_q, hold_valid_q};

    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0;
        if (a_idx < `MFI_A_JOG) begin
            rd_d = {24'h0, func_q[a_idx[5:2]*8 +: 8]};
        end else begin
            case (a_idx)
                `MFI_A_JOG:  rd_d = {16'h0, jog_q};
                `MFI_A_CFG:  rd_d = {24'h0, cfg_q};
                `MFI_A_STAT: rd_d = stat_w;
                `MFI_A_HELD: rd_d = {16'h0, held_q};
                `MFI_A_IRQ:  rd_d = {27'h0, irq_q};
                `MFI_A_MASK: rd_d = {27'h0, mask_q};
                default:     rd_d = 32'h0;
            endcase
        end
    end

    // jog requested while not in the dual-jog stop
    wire jog_any = (jog_fwd | jog_rev) & ~dual_stop_q;
    reg [15:0] freq_d;
    always @* begin
        if (jog_any) begin
            freq_d = jog_q;
        end else if (sh_cfg && hold_valid_q) begin
            freq_d = held_q;
        end else begin
            freq_d = analog_ref_i;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            t_m_q       <= 10'h000;
            t_q         <= 10'h000;
            tick_cnt_q  <= 32'h0;
            tick_q      <= 1'b0;
        end else begin
            t_m_q <= term_i;
            t_q   <= t_m_q;
            tick_q <= (tick_cnt_q == TICK_END);
            if (tick_cnt_q == TICK_END) begin
                tick_cnt_q <= 32'h0;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h1;
            end
        end
    end

    // AHB-Lite slave: zero wait, always OKAY
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_q        <= 1'b0;
            wa_q        <= 6'h00;
            hrdata_q    <= 32'h0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_q <= a_ok & hwrite_i;
            if (a_ok) begin
                wa_q <= a_idx;
            end
            if (a_ok && !hwrite_i) begin
                hrdata_q <= rd_d;
            end
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    integer m;
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (m = 0; m < 10; m = m + 1) begin
                func_q[m*8 +: 8] <= `MFI_FUNC_RST;
            end
            jog_q  <= `MFI_JOG_RST;
            cfg_q  <= `MFI_CFG_RST;
            mask_q <= {`MFI_IRQ_W{1'b0}};
        end else begin
            if (wr_func) begin
                func_q[wf_idx*8 +: 8] <= hwdata_i[7:0];
            end
            // accepted at any time, running or not
            if (wr_jog) begin
                jog_q <= (hwdata_i[15:0] > `MFI_JOG_MAX) ?
                         `MFI_JOG_MAX : hwdata_i[15:0];
            end
            if (wr_cfg) begin
                cfg_q <= hwdata_i[7:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata_i[`MFI_IRQ_W-1:0];
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            held_q       <= 16'h0000;
            hold_valid_q <= 1'b0;
            hold_done_q  <= 1'b0;
            src_q        <= 1'b0;
            dual_stop_q  <= 1'b0;
            fault_q      <= 1'b0;
            fact_q       <= 2'h0;
            fterm_q      <= 4'h0;
            fcont_q      <= 1'b0;
            fwarn_q      <= 1'b0;
            cfg_err_q    <= 1'b0;
            irq_q        <= {`MFI_IRQ_W{1'b0}};
            freq_q       <= 16'h0000;
            jog_run_q    <= 1'b0;
            jog_rev_q    <= 1'b0;
            irq_out_q    <= 1'b0;
        end else begin
            hold_done_q <= hold_done;
            if (ev_hold && sh_cfg) begin
                held_q       <= analog_ref_i;
                hold_valid_q <= 1'b1;
            end
            if (!running_i) begin
                src_q <= src_in;
            end
            if (dual_done) begin
                dual_stop_q <= 1'b1;
            end else if (!(jog_fwd & jog_rev)) begin
                dual_stop_q <= 1'b0;
            end
            if (ef_any && !fault_q) begin
                fault_q <= 1'b1;
                fact_q  <= ef_act;
                fterm_q <= ef_idx + `MFI_TERM_BASE;
                fcont_q <= (ef_act != `MFI_ACT_WARN);
                fwarn_q <= (ef_act == `MFI_ACT_WARN);
            end else if (f_clr && !ef_any) begin
                fault_q <= 1'b0;
                fcont_q <= 1'b0;
                fwarn_q <= 1'b0;
            end
            cfg_err_q <= cfg_err;
            // set wins over a clear in the same cycle
            irq_q     <= (irq_q & ~irq_clr) | ev;
            irq_out_q <= |(((irq_q & ~irq_clr) | ev) & mask_q);
            freq_q    <= freq_d;
            jog_run_q <= jog_any;
            jog_rev_q <= jog_rev & ~jog_fwd & ~dual_stop_q;
        end
    end

    assign hreadyout_o     = hreadyout_q;
    assign hrdata_o        = hrdata_q;
    assign hresp_o         = hresp_q;
    assign freq_ref_o      = freq_q;
    assign src_option_o    = src_q;
    assign jog_run_o       = jog_run_q;
    assign jog_rev_o       = jog_rev_q;
    assign jog_stop_o      = dual_stop_q;
    assign stop_method_o   = cfg_q[5:4];
    assign display_unit_o  = cfg_q[7:6];
    assign fault_contact_o = fcont_q;
    assign fault_warn_o    = fwarn_q;
    assign fault_action_o  = fact_q;
    assign fault_term_o    = fterm_q;
    assign cfg_err_o       = cfg_err_q;
    assign irq_o           = irq_out_q;
endmodule

//--- tb/mfi_chk.sv
// port checker for the multifunction input block
// assumes one clock, sync active-high reset; bound onto mfi_top
`timescale 1ns/1ns
module mfi_chk (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire        running_i,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire [15:0] freq_ref_o,
    input wire        src_option_o,
    input wire        jog_run_o,
    input wire        jog_rev_o,
    input wire        jog_stop_o,
    input wire        fault_contact_o,
    input wire        fault_warn_o,
    input wire [1:0]  fault_action_o,
    input wire [3:0]  fault_term_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_bus;
        hreadyout_o && !hresp_o;
    endproperty
    a_bus: assert property (p_bus) else $error("bus stalled or error");
    property p_pwr;
        $fell(rst_i) |-> freq_ref_o == 16'h0000 && !jog_run_o;
    endproperty
    a_pwr: assert property (p_pwr) else $error("state after power-up");
    // source may only move while the drive was stopped
    property p_src;
        $past(running_i) |-> $stable(src_option_o);
    endproperty
    a_src: assert property (p_src) else $error("source moved in run");
    property p_rev;
        jog_rev_o |-> jog_run_o;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse without jog");
    property p_jogmax;
        jog_run_o && $past(jog_run_o) |-> freq_ref_o <= 16'h2EE0;
    endproperty
    a_jogmax: assert property (p_jogmax) else $error("jog above max");
    property p_stop;
        $rose(jog_stop_o) |-> $past(jog_run_o) ##[0:2] !jog_run_o;
    endproperty
    a_stop: assert property (p_stop) else $error("dual jog stop");
    property p_excl;
        !(fault_contact_o && fault_warn_o);
    endproperty
    a_excl: assert property (p_excl) else $error("error and warn");
    property p_warn;
        (fault_warn_o |-> fault_action_o == 2'h3)
        and (fault_contact_o |-> fault_action_o != 2'h3);
    endproperty
    a_warn: assert property (p_warn) else $error("action mismatch");
    property p_term;
        fault_contact_o || fault_warn_o |->
            fault_term_o >= 4'h3 && fault_term_o <= 4'hC;
    endproperty
    a_term: assert property (p_term) else $error("bad fault terminal");

    c_stop: cover property ($rose(jog_stop_o));
    c_warn: cover property ($rose(fault_warn_o));
    c_src:  cover property ($rose(src_option_o));
endmodule

bind mfi_top mfi_chk u_chk (
    .ref_clk_i,
    .rst_i,
    .running_i,
    .hreadyout_o,
    .hresp_o,
    .freq_ref_o,
    .src_option_o,
    .jog_run_o,
    .jog_rev_o,
    .jog_stop_o,
    .fault_contact_o,
    .fault_warn_o,
    .fault_action_o,
    .fault_term_o
);

//--- tb/mfi_field.sv
// field contacts wired to the ten input terminals
// assumes on_i is the commanded contact state; slow_i adds lag
`timescale 1ns/1ns
module mfi_field (
    input  wire       ref_clk_i,
    input  wire       slow_i,
    input  wire [9:0] on_i,
    output wire [9:0] term_o
);
    logic [9:0] lag1_q;
    logic [9:0] lag2_q;
    // relay contacts settle late; logic must not rely on prompt edges
    always @(posedge ref_clk_i) begin
        lag1_q <= on_i;
        lag2_q <= lag1_q;
    end
    assign term_o = slow_i ? lag2_q : on_i;
endmodule

//--- tb/mfi_top_tb.sv
// self-checking bench for mfi_top over its AHB-Lite port
// assumes TICK_CYC shortened to 10 cycles, so 1 ms is 10 cycles
`timescale 1ns/1ns
`include "mfi_map.vh"
module mfi_top_tb;
    logic        clk, rst, hsel, hwrite, slow, run;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [9:0]  on;
    logic [15:0] aref;
    wire  [9:0]  term;
    wire  [31:0] hrdata;
    wire  [15:0] freq;
    wire  [3:0]  ft;
    wire  [1:0]  fa, sm, du;
    wire         hrdy, src, jrun, jrev, jstop, fc, fw, cerr, irq;
    int          error_cnt = 0;
    int          tests_run = 0;
    localparam logic [39:0] BAD = 40'h0A10111C1D;

    mfi_field u_field (.ref_clk_i(clk), .slow_i(slow), .on_i(on),
                       .term_o(term));
    mfi_top #(.TICK_CYC(10)) uut (
        .ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hrdata_o(hrdata), .hresp_o(), .term_i(term),
        .analog_ref_i(aref), .running_i(run), .freq_ref_o(freq),
        .src_option_o(src), .jog_run_o(jrun), .jog_rev_o(jrev),
        .jog_stop_o(jstop), .stop_method_o(sm), .display_unit_o(du),
        .fault_contact_o(fc), .fault_warn_o(fw), .fault_action_o(fa),
        .fault_term_o(ft), .cfg_err_o(cerr), .irq_o(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up;
        $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(40000 * 8);
        error_cnt++;
        $display("watchdog expired");
        wrap_up;
    end

    task automatic chk(input [31:0] seen, input [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input [5:0] a, input w, input [31:0] d,
                       output [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {26'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input [5:0] a, input [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd(input [5:0] a, input [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
    endtask

    function automatic [8:0] fexp(input [7:0] c);
        fexp = {c < 8'h2C, c >= 8'h2C, c[3:2], 4'h8, c < 8'h2C};
    endfunction

    initial begin
        logic [7:0] c;
        {rst, hsel, hwrite, slow, run} = 5'b10000;
        {haddr, hwdata, htrans, on} = '0;
        aref = 16'h0100;
        do_reset;
        for (int i = 0; i < 10; i++) rd(6'(4 * i), 32'hFF);
        rd(`MFI_A_JOG, 32'h0258);
        rd(`MFI_A_CFG, 32'h05);
        rd(`MFI_A_MASK, 32'h0);
        wr(`MFI_A_JOG, 32'h3000);
        rd(`MFI_A_JOG, 32'h2EE0);
        wr(`MFI_A_STAT, 32'hFFFF);
        rd(`MFI_A_STAT, 32'h0);
        $display("test registers done");
        wr(`MFI_A_CFG, 32'h95);
        wr(`MFI_A_FUNC0, 32'h12);
        wr(`MFI_A_FUNC0 + 6'h04, 32'h13);
        run <= 1'b1;
        aref <= 16'h0777;
        on <= 10'h001;
        wr(`MFI_A_JOG, 32'h1234);
        cyc(8);
        chk(freq, 32'h1234);
        chk({sm, du}, 4'h6);
        chk({jrun, jrev, jstop}, 3'b100);
        on <= 10'h002;
        cyc(8);
        chk({jrun, jrev, jstop}, 3'b110);
        slow <= 1'b1;
        on <= 10'h003;
        cyc(4980);
        chk(jstop, 1'b0);
        cyc(120);
        chk({jrun, jrev, jstop}, 3'b001);
        rd(`MFI_A_IRQ, 32'h02);
        wr(`MFI_A_IRQ, 32'h02);
        on <= 10'h001;
        cyc(20);
        on <= 10'h003;
        cyc(3000);
        on <= 10'h001;
        cyc(20);
        on <= 10'h003;
        cyc(3000);
        chk(jstop, 1'b0);
        on <= 10'h000;
        slow <= 1'b0;
        run <= 1'b0;
        $display("test jog done");
        wr(`MFI_A_FUNC0, 32'hFF);
        wr(`MFI_A_FUNC0 + 6'h04, 32'hFF);
        wr(`MFI_A_FUNC0 + 6'h08, 32'h1E);
        wr(`MFI_A_IRQ, 32'h1F);
        aref <= 16'h0200;
        on <= 10'h004;
        cyc(900);
        on <= 10'h000;
        cyc(8);
        rd(`MFI_A_HELD, 32'h0);
        rd(`MFI_A_STAT, 32'h0);
        on <= 10'h004;
        cyc(990);
        aref <= 16'h0300;
        cyc(110);
        aref <= 16'h0400;
        cyc(10);
        rd(`MFI_A_HELD, 32'h0300);
        chk(freq, 32'h0300);
        rd(`MFI_A_IRQ, 32'h01);
        on <= 10'h000;
        do_reset;
        rd(`MFI_A_HELD, 32'h0);
        rd(`MFI_A_STAT, 32'h0);
        wr(`MFI_A_FUNC0 + 6'h08, 32'h1E);
        for (int k = 0; k < 5; k++) begin
            wr(`MFI_A_FUNC0 + 6'h0C, {24'h0, BAD[8 * k +: 8]});
            cyc(3);
            chk(cerr, 1'b1);
            wr(`MFI_A_FUNC0 + 6'h0C, 32'hFF);
            cyc(3);
            chk(cerr, 1'b0);
        end
        rd(`MFI_A_IRQ, 32'h10);
        wr(`MFI_A_MASK, 32'h10);
        cyc(3);
        chk(irq, 1'b1);
        wr(`MFI_A_IRQ, 32'h10);
        cyc(3);
        chk(irq, 1'b0);
        wr(`MFI_A_FUNC0 + 6'h08, 32'hFF);
        $display("test hold done");
        wr(`MFI_A_FUNC0 + 6'h10, 32'h02);
        run <= 1'b1;
        on <= 10'h010;
        cyc(8);
        chk(src, 1'b0);
        run <= 1'b0;
        cyc(8);
        chk(src, 1'b1);
        rd(`MFI_A_STAT, 32'h02);
        on <= 10'h000;
        cyc(8);
        chk(src, 1'b0);
        wr(`MFI_A_FUNC0 + 6'h10, 32'hFF);
        $display("test source done");
        wr(`MFI_A_MASK, 32'h04);
        for (int k = 0; k < 16; k++) begin
            c = 8'h20 + 8'(k);
            on <= c[0] ? 10'h020 : 10'h000;
            run <= 1'b0;
            wr(`MFI_A_FUNC0 + 6'h14, {24'h0, c});
            cyc(8);
            chk({fc, fw}, 2'b00);
            on <= c[0] ? 10'h000 : 10'h020;
            cyc(8);
            if (c[1])
                chk({fc, fw, irq}, 3'b000);
            else
                chk({fc, fw, fa, ft, irq}, fexp(c));
            run <= 1'b1;
            cyc(8);
            chk({fc, fw, fa, ft, irq}, fexp(c));
            on <= c[0] ? 10'h020 : 10'h000;
            run <= 1'b0;
            cyc(8);
            wr(`MFI_A_IRQ, 32'h0C);
            cyc(3);
            chk({fc, fw, irq}, 3'b000);
            wr(`MFI_A_FUNC0 + 6'h14, 32'hFF);
        end
        $display("test fault done");
        wrap_up;
    end
endmodule
